//--- src/omd_regs.svh
`ifndef OMD_REGS_SVH
`define OMD_REGS_SVH
// ----------------------------------------
// Escape and prefix byte values
// ----------------------------------------
`define OMD_ESC_0F 8'h0f
`define OMD_ESC_38 8'h38
`define OMD_ESC_3A 8'h3a
`define OMD_PFX_OPSZ 8'h66
`define OMD_PFX_REPNE 8'hf2
`define OMD_PFX_REP 8'hf3
// Float escapes occupy d8..df, upper five bits fixed
`define OMD_FLT_HI 5'h1b
// Memory-form limit of the float specifier byte (00..bf)
`define OMD_FLT_MEM_MAX 8'hbf
// ----------------------------------------
// Field positions of the operand specifier byte
// ----------------------------------------
`define OMD_MOD_HI 7
`define OMD_MOD_LO 6
`define OMD_REG_HI 5
`define OMD_REG_LO 3
`define OMD_RM_HI 2
`define OMD_RM_LO 0
`define OMD_MOD_REG 2'h3
// ----------------------------------------
// Fixed register and segment codes
// ----------------------------------------
`define OMD_SEG_ES 3'h0
`define OMD_SEG_DS 3'h3
`define OMD_IDX_SI 4'h6
`define OMD_IDX_DI 4'h7
`endif

//--- src/omd_pkg.sv
// ----------------------------------------
// Shared types of the opcode map decoder
// ----------------------------------------
package omd_pkg;
  // Which map a lookup indexes
  typedef enum logic [1:0] {
    MAP_ONE = 2'b00,
    MAP_TWO = 2'b01,
    MAP_T38 = 2'b10,
    MAP_T3A = 2'b11
  } omd_map_e;
  // Addressing method of an operand
  typedef enum logic [4:0] {
    AM_A = 5'h00, AM_C = 5'h01, AM_D = 5'h02, AM_E = 5'h03,
    AM_F = 5'h04, AM_G = 5'h05, AM_I = 5'h06, AM_J = 5'h07,
    AM_M = 5'h08, AM_N = 5'h09, AM_O = 5'h0a, AM_P = 5'h0b,
    AM_Q = 5'h0c, AM_R = 5'h0d, AM_S = 5'h0e, AM_U = 5'h0f,
    AM_V = 5'h10, AM_W = 5'h11, AM_X = 5'h12, AM_Y = 5'h13
  } omd_method_e;
  // Operand type
  typedef enum logic [3:0] {
    OT_A = 4'h0, OT_B = 4'h1, OT_C = 4'h2, OT_D = 4'h3,
    OT_DQ = 4'h4, OT_P = 4'h5, OT_PI = 4'h6, OT_PS = 4'h7,
    OT_Q = 4'h8, OT_S = 4'h9, OT_SS = 4'ha, OT_SI = 4'hb,
    OT_V = 4'hc, OT_W = 4'hd, OT_Z = 4'he
  } omd_type_e;
  // Operand-size attribute
  typedef enum logic [1:0] {
    OS_16 = 2'b00,
    OS_32 = 2'b01,
    OS_64 = 2'b10
  } omd_osz_e;
  // Decoder position in the byte stream
  typedef enum logic [1:0] {
    ST_OPC = 2'b00,
    ST_ESC = 2'b01,
    ST_ESC3 = 2'b10,
    ST_SPEC = 2'b11
  } omd_state_e;
endpackage

//--- src/omd_core.sv
// Function
// - One-byte map: high nibble row, low column
// - Skip prefixes and 0F, index two-byte map
// - Skip prefixes and 0F38/0F3A, index third byte
// - Specifier reg field extends grouped opcodes
// - Float memory form: escape plus bits 3-5
// - Float register form: whole specifier byte
// - Direct address: no specifier, no base/index
// - Reg field selects control or debug register
// - Register-or-memory specifier with full address
// - Reg field selects general register, 000 accumulator
// - Memory-only needs memory; register-only R needs register, N and U are not checked
// - Direct offset: no specifier, address-size width
// - Quadword vector register by reg or r/m
// - Wide vector register by reg or r/m
// - Reg field selects segment register
// - String source DS:SI, destination ES:DI
// - Immediate follows; relative adds to pointer
// - Fixed types ignore size; z word or dword
// - Pointer, descriptor, v sizes by attribute
// - Size-dependent register width follows attribute
// - Extension bit selects extended register for G reg-field operands only
`timescale 1ns/100ps
`default_nettype none
`include "omd_regs.svh"
module omd_core (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Instruction byte stream from fetch
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  // Mode attributes
  input wire omd_pkg::omd_osz_e op_size,
  input wire logic addr_size_32,
  input wire logic register_extension_bit,
  // Map table lookup, combinational on this clock
  output logic lk_en,
  output omd_pkg::omd_map_e lk_map,
  output logic [3:0] lk_row,
  output logic [3:0] lk_col,
  input wire logic lk_present,
  input wire logic lk_has_spec,
  input wire logic lk_group,
  input wire omd_pkg::omd_method_e lk_method,
  input wire omd_pkg::omd_type_e lk_type,
  // Decoded result to execution
  output logic dec_valid,
  output logic dec_undef,
  output omd_pkg::omd_map_e dec_map,
  output logic [3:0] dec_row,
  output logic [3:0] dec_col,
  output logic dec_ext_valid,
  output logic [2:0] dec_ext,
  output logic dec_float,
  output logic dec_flt_regform,
  output logic [2:0] dec_flt_esc,
  output logic [7:0] dec_flt_op,
  output omd_pkg::omd_method_e dec_method,
  output logic dec_is_mem,
  output logic [3:0] dec_reg,
  output logic [2:0] dec_seg,
  output logic [7:0] dec_bits,
  output logic [5:0] dec_offset_bits,
  output logic dec_imm_follows,
  output logic dec_rel_follows
);
  import omd_pkg::*;

  // ----------------------------------------
  // Byte classification
  // ----------------------------------------
  omd_state_e state_q; // Position in the opcode bytes
  omd_state_e state_d; // Next position
  logic is_prefix; // Byte is any instruction prefix
  logic is_flt; // Byte is a float escape opcode
  logic emit; // Result is registered this cycle
  logic emit_undef; // Result is undefined
  logic [7:0] spec; // Specifier byte used for the result
  logic esc3_q; // Second escape was 3a

  // Prefixes are skipped only in ST_OPC, before the first opcode byte
  always_comb begin
    case (byte_data)
      8'h26, 8'h2e, 8'h36, 8'h3e, 8'h64, 8'h65, 8'h67, 8'hf0,
      `OMD_PFX_OPSZ, `OMD_PFX_REPNE, `OMD_PFX_REP: is_prefix = 1'b1;
      default: is_prefix = 1'b0;
    endcase
  end

  assign is_flt = (byte_data[7:3] == `OMD_FLT_HI);

  // ----------------------------------------
  // Map lookup addressing
  // ----------------------------------------
  // Lookup runs on the byte that finally names the opcode
  always_comb begin
    lk_en = 1'b0;
    lk_map = MAP_ONE;
    case (state_q)
      ST_OPC: begin
        lk_en = byte_valid && !is_prefix && !is_flt &&
                (byte_data != `OMD_ESC_0F);
        lk_map = MAP_ONE;
      end
      ST_ESC: begin
        lk_en = byte_valid && (byte_data != `OMD_ESC_38) &&
                (byte_data != `OMD_ESC_3A);
        lk_map = MAP_TWO;
      end
      ST_ESC3: begin
        lk_en = byte_valid;
        lk_map = esc3_q ? MAP_T3A : MAP_T38;
      end
      default: begin
        lk_en = 1'b0;
        lk_map = MAP_ONE;
      end
    endcase
  end

  // Row from the high nibble, column from the low
  assign lk_row = byte_data[7:4];
  assign lk_col = byte_data[3:0];

  // ----------------------------------------
  // Opcode latch while waiting for the specifier
  // ----------------------------------------
  logic flt_q; // Pending opcode is a float escape
  logic [2:0] flt_esc_q; // Low bits of the float escape
  omd_map_e map_q; // Pending map
  logic [3:0] row_q; // Pending row
  logic [3:0] col_q; // Pending column
  logic group_q; // Pending opcode uses an extension
  omd_method_e meth_q; // Pending addressing method
  omd_type_e type_q; // Pending operand type

  // Direct address and offset forms never wait for a specifier
  logic need_spec;
  assign need_spec = lk_has_spec && (lk_method != AM_A) &&
                     (lk_method != AM_O);

  // Capture what the lookup said about the opcode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      esc3_q <= 1'b0;
      flt_q <= 1'b0;
      flt_esc_q <= 3'h0;
      map_q <= MAP_ONE;
      row_q <= 4'h0;
      col_q <= 4'h0;
      group_q <= 1'b0;
      meth_q <= AM_E;
      type_q <= OT_V;
    end else if (byte_valid) begin
      if (state_q == ST_ESC) begin
        esc3_q <= (byte_data == `OMD_ESC_3A);
      end
      if (state_q == ST_OPC && is_flt) begin
        flt_q <= 1'b1;
        flt_esc_q <= byte_data[2:0];
        meth_q <= AM_E;
        type_q <= OT_V;
      end else if (lk_en) begin
        flt_q <= 1'b0;
        map_q <= lk_map;
        row_q <= lk_row;
        col_q <= lk_col;
        group_q <= lk_group;
        meth_q <= lk_method;
        type_q <= lk_type;
      end
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Bytes after the specifier (displacement, immediate) pass on
  // to execution; this front end does not count them
  always_comb begin
    state_d = state_q;
    emit = 1'b0;
    emit_undef = 1'b0;
    if (byte_valid) begin
      case (state_q)
        ST_OPC: begin
          if (is_prefix) begin
            state_d = ST_OPC;
          end else if (byte_data == `OMD_ESC_0F) begin
            state_d = ST_ESC;
          end else if (is_flt) begin
            state_d = ST_SPEC;
          end
        end
        ST_ESC: begin
          if (byte_data == `OMD_ESC_38 || byte_data == `OMD_ESC_3A) begin
            state_d = ST_ESC3;
          end
        end
        ST_SPEC: begin
          emit = 1'b1;
          state_d = ST_OPC;
          // Form checks on mod
          if (!flt_q && meth_q == AM_M &&
              spec[`OMD_MOD_HI:`OMD_MOD_LO] == `OMD_MOD_REG) begin
            emit_undef = 1'b1;
          end
          if (!flt_q && meth_q == AM_R &&
              spec[`OMD_MOD_HI:`OMD_MOD_LO] != `OMD_MOD_REG) begin
            emit_undef = 1'b1;
          end
        end
        default: state_d = ST_OPC;
      endcase
      if (lk_en) begin
        // Empty positions end the opcode at once
        if (!lk_present) begin
          emit = 1'b1;
          emit_undef = 1'b1;
          state_d = ST_OPC;
        end else if (need_spec) begin
          state_d = ST_SPEC;
        end else begin
          emit = 1'b1;
          state_d = ST_OPC;
        end
      end
    end
  end

  // Position register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_OPC;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Operand resolution
  // ----------------------------------------
  omd_map_e r_map; // Map of the emitted opcode
  logic [3:0] r_row; // Row of the emitted opcode
  logic [3:0] r_col; // Column of the emitted opcode
  logic r_grp; // Extension applies
  omd_method_e r_meth; // Method of the emitted operand
  omd_type_e r_type; // Type of the emitted operand
  logic r_has_spec; // A specifier byte was read
  logic r_mem; // Operand is in memory
  logic [3:0] r_reg; // Register selector
  logic [2:0] r_seg; // Segment for string operands
  logic [7:0] r_bits; // Operand width in bits

  // Specifier is the current byte only when it is consumed as one
  assign spec = (state_q == ST_SPEC) ? byte_data : 8'h00;

  // Choose latched or live lookup data
  always_comb begin
    r_has_spec = (state_q == ST_SPEC);
    r_map = r_has_spec ? map_q : lk_map;
    r_row = r_has_spec ? row_q : lk_row;
    r_col = r_has_spec ? col_q : lk_col;
    r_grp = r_has_spec ? group_q : 1'b0;
    r_meth = r_has_spec ? meth_q : lk_method;
    r_type = r_has_spec ? type_q : lk_type;
  end

  // Operand location by addressing method
  always_comb begin
    r_mem = 1'b0;
    r_reg = 4'h0;
    r_seg = `OMD_SEG_DS;
    case (r_meth)
      // No specifier: the address is in the instruction
      AM_A, AM_O: r_mem = 1'b1;
      // Reg field names control, debug or segment register
      AM_C, AM_D, AM_S: begin
        r_reg = {1'b0, spec[`OMD_REG_HI:`OMD_REG_LO]};
      end
      // Accumulator is 000; extension picks r8..r15
      AM_G: begin
        r_reg = {register_extension_bit,
                 spec[`OMD_REG_HI:`OMD_REG_LO]};
      end
      // Vector registers by reg field
      AM_P, AM_V: begin
        r_reg = {1'b0, spec[`OMD_REG_HI:`OMD_REG_LO]};
      end
      // Register-only forms by r/m
      AM_N, AM_U, AM_R: begin
        r_reg = {1'b0, spec[`OMD_RM_HI:`OMD_RM_LO]};
      end
      // Register or computed memory address
      AM_E, AM_Q, AM_W, AM_M: begin
        r_mem = (spec[`OMD_MOD_HI:`OMD_MOD_LO] != `OMD_MOD_REG);
        r_reg = {1'b0, spec[`OMD_RM_HI:`OMD_RM_LO]};
      end
      // String operands use fixed segment and index
      AM_X: begin
        r_mem = 1'b1;
        r_seg = `OMD_SEG_DS;
        r_reg = `OMD_IDX_SI;
      end
      AM_Y: begin
        r_mem = 1'b1;
        r_seg = `OMD_SEG_ES;
        r_reg = `OMD_IDX_DI;
      end
      default: begin
        r_mem = 1'b0;
        r_reg = 4'h0;
      end
    endcase
  end

  // Width by type and operand-size attribute
  always_comb begin
    case (r_type)
      OT_B: r_bits = 8'h08;
      OT_W: r_bits = 8'h10;
      OT_D, OT_SS, OT_SI: r_bits = 8'h20;
      OT_Q, OT_PI: r_bits = 8'h40;
      OT_DQ, OT_PS: r_bits = 8'h80;
      OT_C: r_bits = (op_size == OS_16) ? 8'h10 : 8'h08;
      OT_Z: r_bits = (op_size == OS_16) ? 8'h10 : 8'h20;
      OT_P: r_bits = (op_size == OS_16) ? 8'h20 : 8'h30;
      OT_S: r_bits = (op_size == OS_16) ? 8'h30 : 8'h50;
      OT_A: r_bits = (op_size == OS_16) ? 8'h20 : 8'h40;
      // Register width tracks the attribute
      OT_V: begin
        if (op_size == OS_16) begin
          r_bits = 8'h10;
        end else if (op_size == OS_64) begin
          r_bits = 8'h40;
        end else begin
          r_bits = 8'h20;
        end
      end
      default: r_bits = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Result register
  // ----------------------------------------
  // One pulse per opcode; fields hold until the next result
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dec_valid <= 1'b0;
      dec_undef <= 1'b0;
      dec_map <= MAP_ONE;
      dec_row <= 4'h0;
      dec_col <= 4'h0;
      dec_ext_valid <= 1'b0;
      dec_ext <= 3'h0;
      dec_float <= 1'b0;
      dec_flt_regform <= 1'b0;
      dec_flt_esc <= 3'h0;
      dec_flt_op <= 8'h00;
      dec_method <= AM_E;
      dec_is_mem <= 1'b0;
      dec_reg <= 4'h0;
      dec_seg <= `OMD_SEG_DS;
      dec_bits <= 8'h00;
      dec_offset_bits <= 6'h00;
      dec_imm_follows <= 1'b0;
      dec_rel_follows <= 1'b0;
    end else begin
      dec_valid <= emit;
      if (emit) begin
        dec_undef <= emit_undef;
        dec_map <= r_map;
        dec_row <= r_row;
        dec_col <= r_col;
        dec_ext_valid <= r_grp && !flt_q;
        dec_ext <= spec[`OMD_REG_HI:`OMD_REG_LO];
        dec_float <= r_has_spec && flt_q;
        dec_flt_esc <= flt_esc_q;
        // Memory form keeps bits 3-5, register form the whole byte
        dec_flt_regform <= (spec > `OMD_FLT_MEM_MAX);
        dec_flt_op <= (spec > `OMD_FLT_MEM_MAX) ? spec :
                      {5'h00, spec[`OMD_REG_HI:`OMD_REG_LO]};
        dec_method <= r_meth;
        dec_is_mem <= r_mem;
        dec_reg <= r_reg;
        dec_seg <= r_seg;
        dec_bits <= r_bits;
        dec_offset_bits <= addr_size_32 ? 6'h20 : 6'h10;
        dec_imm_follows <= (r_meth == AM_I);
        dec_rel_follows <= (r_meth == AM_J);
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence esc_seen;
    byte_valid && state_q == ST_OPC && byte_data == `OMD_ESC_0F;
  endsequence
  sequence spec_take;
    byte_valid && state_q == ST_SPEC;
  endsequence

  one_byte_map_a: assert property (lk_en && state_q == ST_OPC &&
    lk_present && !need_spec |=> dec_valid && dec_map == MAP_ONE &&
    dec_row == $past(byte_data[7:4]) && dec_col == $past(byte_data[3:0]))
    else $error("one-byte row or column wrong");
  two_byte_map_a: assert property (esc_seen ##1 (byte_valid &&
    byte_data != `OMD_ESC_38 && byte_data != `OMD_ESC_3A) |-> lk_en &&
    lk_map == MAP_TWO) else $error("two-byte map not indexed");
  three_byte_map_a: assert property (esc_seen ##1 (byte_valid &&
    byte_data == `OMD_ESC_38) ##1 byte_valid |-> lk_en && lk_map == MAP_T38)
    else $error("three-byte map not indexed");
  undef_flag_a: assert property (lk_en && !lk_present |=>
    dec_valid && dec_undef && state_q == ST_OPC)
    else $error("empty position not flagged");
  float_mem_a: assert property (spec_take and (flt_q &&
    byte_data <= `OMD_FLT_MEM_MAX) |=> dec_float && !dec_flt_regform &&
    dec_flt_op == {5'h00, $past(byte_data[5:3])})
    else $error("float memory form wrong");
  float_reg_a: assert property (spec_take and (flt_q &&
    byte_data > `OMD_FLT_MEM_MAX) |=> dec_flt_regform &&
    dec_flt_op == $past(byte_data)) else $error("float register form wrong");
  direct_addr_a: assert property (lk_en && lk_present &&
    lk_method == AM_A |-> state_d == ST_OPC ##1 dec_valid && dec_is_mem)
    else $error("direct address waited for specifier");
  mem_only_a: assert property (spec_take and (!flt_q &&
    meth_q == AM_M && byte_data[7:6] == `OMD_MOD_REG) |=> dec_undef)
    else $error("memory-only accepted register form");
  string_dst_a: assert property (emit && r_meth == AM_Y |=>
    dec_seg == `OMD_SEG_ES && dec_reg == `OMD_IDX_DI && dec_is_mem)
    else $error("string destination pointer wrong");
  size_z_a: assert property (emit && r_type == OT_Z |=>
    dec_bits == (($past(op_size) == OS_16) ? 8'h10 : 8'h20))
    else $error("z operand width wrong");
endmodule
`default_nettype wire

//--- test/omd_map_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Opcode map table seen by the decoder
// ----------------------------------------
module omd_map_model (
  // Clock for idle junk
  input wire logic clk,
  // Lookup request
  input wire logic lk_en,
  input wire omd_pkg::omd_map_e lk_map,
  input wire logic [3:0] lk_row,
  input wire logic [3:0] lk_col,
  // Lookup answer
  output logic lk_present,
  output logic lk_has_spec,
  output logic lk_group,
  output omd_pkg::omd_method_e lk_method,
  output omd_pkg::omd_type_e lk_type
);
  import omd_pkg::*;
  logic tog_q = 1'b0; // Flips so idle answers never settle
  logic pr; // Position defined
  logic sp; // Specifier follows
  logic gr; // Grouped opcode
  omd_method_e me; // Method of the entry
  omd_type_e ty; // Type of the entry
  // Idle toggle
  always_ff @(posedge clk) begin
    tog_q <= ~tog_q;
  end
  // Small table, contents made up for the tests
  always_comb begin
    pr = 1'b1;
    sp = 1'b1;
    gr = 1'b0;
    me = AM_E;
    ty = OT_V;
    case ({lk_map, lk_row, lk_col})
      {MAP_ONE, 8'h03}: me = AM_G;
      {MAP_ONE, 8'h02}: begin me = AM_G; ty = OT_B; end
      {MAP_ONE, 8'h80}: begin gr = 1'b1; ty = OT_B; end
      {MAP_ONE, 8'h8c}: begin me = AM_S; ty = OT_W; end
      {MAP_ONE, 8'h62}: begin me = AM_M; ty = OT_A; end
      {MAP_ONE, 8'ha0}: begin me = AM_O; ty = OT_B; sp = 1'b0; end
      {MAP_ONE, 8'hea}: begin me = AM_A; ty = OT_P; sp = 1'b0; end
      {MAP_ONE, 8'ha4}: begin me = AM_X; ty = OT_B; sp = 1'b0; end
      {MAP_ONE, 8'haa}: begin me = AM_Y; ty = OT_B; sp = 1'b0; end
      {MAP_ONE, 8'h68}: begin me = AM_I; ty = OT_Z; sp = 1'b0; end
      {MAP_ONE, 8'he9}: begin me = AM_J; ty = OT_Z; sp = 1'b0; end
      {MAP_ONE, 8'hd8}, {MAP_ONE, 8'hd9}, {MAP_ONE, 8'hdd}: ;
      {MAP_TWO, 8'ha4}: ;
      {MAP_TWO, 8'h20}: begin me = AM_R; ty = OT_D; end
      {MAP_TWO, 8'h21}: begin me = AM_D; ty = OT_D; end
      {MAP_TWO, 8'h22}: begin me = AM_C; ty = OT_D; end
      {MAP_TWO, 8'h10}: begin me = AM_W; ty = OT_PS; end
      {MAP_T3A, 8'h0f}: begin me = AM_V; ty = OT_DQ; end
      {MAP_T38, 8'h00}: begin me = AM_P; ty = OT_Q; end
      // Everything else is an empty position
      default: begin pr = 1'b0; sp = 1'b0; end
    endcase
  end
  // Outside a lookup the answer is junk
  assign lk_present = lk_en ? pr : tog_q;
  assign lk_has_spec = lk_en ? sp : ~tog_q;
  assign lk_group = lk_en ? gr : tog_q;
  assign lk_method = lk_en ? me : omd_method_e'({4'h0, tog_q});
  assign lk_type = lk_en ? ty : omd_type_e'({3'h0, tog_q});
endmodule
`default_nettype wire

//--- test/opcode_map_decoder_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module opcode_map_decoder_tb_top;
  import omd_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk;
  logic sys_rst = 1'b1;
  logic byte_valid = 1'b0;
  logic [7:0] byte_data = 8'h00;
  omd_osz_e op_size = OS_32;
  logic addr_size_32 = 1'b0;
  logic register_extension_bit = 1'b0;
  logic lk_en, lk_present, lk_has_spec, lk_group;
  omd_map_e lk_map, dec_map;
  logic [3:0] lk_row, lk_col, dec_row, dec_col, dec_reg;
  omd_method_e lk_method, dec_method;
  omd_type_e lk_type;
  logic dec_valid, dec_undef, dec_ext_valid, dec_float, dec_flt_regform;
  logic [2:0] dec_ext, dec_flt_esc, dec_seg;
  logic [7:0] dec_flt_op, dec_bits;
  logic [5:0] dec_offset_bits;
  logic dec_is_mem, dec_imm_follows, dec_rel_follows;
  int fails = 0; // Mismatches
  int tests_run = 0; // Comparisons
  int cyc = 0; // Cycles elapsed
  // ----------------------------------------
  // Design and map table
  // ----------------------------------------
  omd_core dut (.clk(clk), .sys_rst(sys_rst), .byte_valid(byte_valid),
    .byte_data(byte_data), .op_size(op_size), .addr_size_32(addr_size_32),
    .register_extension_bit(register_extension_bit), .lk_en(lk_en),
    .lk_map(lk_map), .lk_row(lk_row), .lk_col(lk_col),
    .lk_present(lk_present), .lk_has_spec(lk_has_spec),
    .lk_group(lk_group), .lk_method(lk_method), .lk_type(lk_type),
    .dec_valid(dec_valid), .dec_undef(dec_undef), .dec_map(dec_map),
    .dec_row(dec_row), .dec_col(dec_col), .dec_ext_valid(dec_ext_valid),
    .dec_ext(dec_ext), .dec_float(dec_float),
    .dec_flt_regform(dec_flt_regform), .dec_flt_esc(dec_flt_esc),
    .dec_flt_op(dec_flt_op), .dec_method(dec_method),
    .dec_is_mem(dec_is_mem), .dec_reg(dec_reg), .dec_seg(dec_seg),
    .dec_bits(dec_bits), .dec_offset_bits(dec_offset_bits),
    .dec_imm_follows(dec_imm_follows), .dec_rel_follows(dec_rel_follows));
  omd_map_model tbl (.clk(clk), .lk_en(lk_en), .lk_map(lk_map),
    .lk_row(lk_row), .lk_col(lk_col), .lk_present(lk_present),
    .lk_has_spec(lk_has_spec), .lk_group(lk_group),
    .lk_method(lk_method), .lk_type(lk_type));
  // ----------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Ceiling well above the roughly 150 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_sim();
    end
  end
  // Compare and count
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Feed one instruction, expect a single pulse after its last byte
  task run(input logic [7:0] q[$]);
    for (int i = 0; i < q.size(); i++) begin
      @(negedge clk);
      if (i > 0) chk("early valid", dec_valid, 8'h00);
      byte_valid = 1'b1;
      byte_data = q[i];
    end
    @(negedge clk);
    byte_valid = 1'b0;
    byte_data = ~byte_data; // Idle bus shows no stale byte
    chk("dec_valid", dec_valid, 8'h01);
    @(negedge clk);
    chk("pulse end", dec_valid, 8'h00);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_one;
    op_size = OS_32;
    run('{8'h03, 8'h05});
    chk("map", dec_map, MAP_ONE);
    chk("row", dec_row, 8'h00);
    chk("col", dec_col, 8'h03);
    chk("method", dec_method, AM_G);
    chk("acc", dec_reg, 8'h00);
    chk("bits", dec_bits, 8'd32);
    chk("undef", dec_undef, 8'h00);
  endtask
  task t_gext;
    op_size = OS_64;
    register_extension_bit = 1'b1;
    run('{8'h03, 8'hd8});
    chk("ext reg", dec_reg, 8'h0b);
    chk("bits", dec_bits, 8'd64);
    op_size = OS_16;
    run('{8'h02, 8'hd8});
    chk("fixed b", dec_bits, 8'd8);
    register_extension_bit = 1'b0;
    run('{8'h03, 8'hd8});
    chk("reg", dec_reg, 8'h03);
    chk("bits", dec_bits, 8'd16);
  endtask
  task t_two;
    run('{8'h66, 8'h0f, 8'ha4, 8'h05});
    chk("map", dec_map, MAP_TWO);
    chk("row", dec_row, 8'h0a);
    chk("col", dec_col, 8'h04);
    chk("mem", dec_is_mem, 8'h01);
    chk("rm", dec_reg, 8'h05);
    run('{8'h0f, 8'ha4, 8'hc3});
    chk("reg form", dec_is_mem, 8'h00);
    chk("rm", dec_reg, 8'h03);
  endtask
  task t_three;
    run('{8'h66, 8'h0f, 8'h3a, 8'h0f, 8'hc1});
    chk("map", dec_map, MAP_T3A);
    chk("row", dec_row, 8'h00);
    chk("col", dec_col, 8'h0f);
    chk("method", dec_method, AM_V);
    chk("reg", dec_reg, 8'h00);
    chk("bits", dec_bits, 8'h80);
    run('{8'h0f, 8'h38, 8'h00, 8'h28});
    chk("map", dec_map, MAP_T38);
    chk("method", dec_method, AM_P);
    chk("reg", dec_reg, 8'h05);
    run('{8'h0f, 8'h10, 8'h0a});
    chk("w mem", dec_is_mem, 8'h01);
    chk("w rm", dec_reg, 8'h02);
    chk("w bits", dec_bits, 8'h80);
  endtask
  task t_group;
    run('{8'h80, 8'h38});
    chk("ext v", dec_ext_valid, 8'h01);
    chk("ext", dec_ext, 8'h07);
    run('{8'h03, 8'h38});
    chk("no ext", dec_ext_valid, 8'h00);
  endtask
  // Memory and register forms, bf and c0 on the boundary
  task t_float;
    static logic [7:0] es [5] = '{8'hd9, 8'hd9, 8'hd9, 8'hdd, 8'hd8};
    static logic [7:0] sb [5] = '{8'hc1, 8'h05, 8'hbf, 8'h1e, 8'hc0};
    logic rf;
    for (int i = 0; i < 5; i++) begin
      run('{es[i], sb[i]});
      rf = sb[i] > 8'hbf;
      chk("float", dec_float, 8'h01);
      chk("esc", dec_flt_esc, es[i][2:0]);
      chk("regform", dec_flt_regform, rf);
      chk("op", dec_flt_op, rf ? sb[i] : {5'h0, sb[i][5:3]});
    end
  endtask
  task t_direct;
    addr_size_32 = 1'b0;
    run('{8'ha0});
    chk("method", dec_method, AM_O);
    chk("off16", dec_offset_bits, 8'd16);
    addr_size_32 = 1'b1;
    run('{8'ha0});
    chk("off32", dec_offset_bits, 8'd32);
    op_size = OS_16;
    run('{8'hea});
    chk("method", dec_method, AM_A);
    chk("ptr16", dec_bits, 8'd32);
    op_size = OS_32;
    run('{8'hea});
    chk("ptr32", dec_bits, 8'd48);
  endtask
  task t_regs;
    run('{8'h8c, 8'h18});
    chk("method", dec_method, AM_S);
    chk("seg", dec_reg, 8'h03);
    run('{8'h0f, 8'h22, 8'hd8});
    chk("method", dec_method, AM_C);
    chk("ctl", dec_reg, 8'h03);
    run('{8'h0f, 8'h21, 8'hd0});
    chk("method", dec_method, AM_D);
    chk("dbg", dec_reg, 8'h02);
  endtask
  task t_only;
    op_size = OS_16;
    run('{8'h62, 8'hc0});
    chk("m reg", dec_undef, 8'h01);
    run('{8'h62, 8'h06});
    chk("m mem", dec_undef, 8'h00);
    chk("mem", dec_is_mem, 8'h01);
    chk("pair", dec_bits, 8'd32);
    run('{8'h0f, 8'h20, 8'h05});
    chk("r mem", dec_undef, 8'h01);
    run('{8'h0f, 8'h20, 8'hc5});
    chk("r reg", dec_undef, 8'h00);
    chk("rm", dec_reg, 8'h05);
  endtask
  task t_str;
    run('{8'ha4});
    chk("src reg", dec_reg, 8'h06);
    chk("src seg", dec_seg, 8'h03);
    run('{8'haa});
    chk("dst reg", dec_reg, 8'h07);
    chk("dst seg", dec_seg, 8'h00);
  endtask
  task t_imm;
    op_size = OS_16;
    run('{8'h68});
    chk("imm", dec_imm_follows, 8'h01);
    chk("z16", dec_bits, 8'd16);
    op_size = OS_64;
    run('{8'h68});
    chk("z64", dec_bits, 8'd32);
    run('{8'he9});
    chk("rel", dec_rel_follows, 8'h01);
    chk("no imm", dec_imm_follows, 8'h00);
  endtask
  // Only this scenario feeds an empty position
  task t_undef;
    run('{8'hd6});
    chk("undef", dec_undef, 8'h01);
    run('{8'h03, 8'h05});
    chk("defined", dec_undef, 8'h00);
  endtask
  // Reset in mid-instruction must drop the pending escape
  task t_rst;
    @(negedge clk);
    byte_valid = 1'b1;
    byte_data = 8'h0f;
    @(negedge clk);
    byte_valid = 1'b0;
    sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0;
    chk("rst valid", dec_valid, 8'h00);
    chk("rst bits", dec_bits, 8'h00);
    chk("rst method", dec_method, AM_E);
    run('{8'h03, 8'h05});
    chk("map", dec_map, MAP_ONE);
    chk("undef", dec_undef, 8'h00);
  endtask
  // ----------------------------------------
  // Main sequence and verdict
  // ----------------------------------------
  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    t_one();
    t_gext();
    t_two();
    t_three();
    t_group();
    t_float();
    t_direct();
    t_regs();
    t_only();
    t_str();
    t_imm();
    t_undef();
    t_rst();
    end_sim();
  end
endmodule
`default_nettype wire
